// ==== verilog/vdft_frame_timing.sv ====
// Display channel frame timing: control and frame size registers, pixel and
// line position counters, field selection and one-shot or repeating display.
// Assumes a same-clock register master (one-cycle strobes, read data next
// cycle) and that the pixel rate is sys_clk gated by clk_en.
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Repeat bit set keeps frames displaying continuously
// - Whole-picture bit shows full frame, else not
// - Second-field bit shows field two, else skipped
// - First-field bit shows field one, else skipped
// - Control bit three reads zero, ignores writes
// - Format field selects ITU, raw8, luma-chroma, format_16bit_unformatted
// - Pixel counter runs zero to width minus one
// - Line counter runs one to programmed height
// - Size bits 27..16 hold lines per picture
// - Size bits 11..0 hold pixels per line
// - Size reserved bits read zero, ignore writes
module vdft_frame_timing (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Register port
  input wire vdft_pkg::vdft_bus_req_s bus_req,
  output logic [31:0] bus_rdata,
  // Timing toward the encoder
  output vdft_pkg::vdft_timing_s timing,
  output vdft_pkg::vdft_format_s format_sel,
  output logic blanking_disable
);

  // ****************************************
  // Decode helpers
  // ****************************************
  // Used only by the registered format select flags, not the status word
  function automatic vdft_pkg::vdft_format_s decode_format(
    input logic [vdft_pkg::FMT_W-1:0] code
  );
    vdft_pkg::vdft_format_s f;
    f = '0;
    case (code)
      vdft_pkg::FORMAT_8BIT_ITU: f.fmt_8bit_itu = 1'b1;
      vdft_pkg::FORMAT_8BIT_UNFORMATTED: f.fmt_8bit_unformatted = 1'b1;
      vdft_pkg::FORMAT_LUMA_CHROMA: f.fmt_luma_chroma = 1'b1;
      vdft_pkg::FORMAT_16BIT_UNFORMATTED: f.fmt_16bit_unformatted = 1'b1;
      default: f = '0;
    endcase
    return f;
  endfunction

  function automatic logic addr_hit(
    input logic [vdft_pkg::ADDR_W-1:0] a,
    input logic [vdft_pkg::ADDR_W-1:0] ofs
  );
    return a == ofs;
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  logic [vdft_pkg::FMT_W-1:0] format_q;
  logic show_first_field_q;
  logic show_second_field_q;
  logic show_whole_picture_q;
  logic repeat_display_enable_q;
  logic display_enable_bit_q;
  logic blanking_disable_bit_q;
  logic [vdft_pkg::CNT_W-1:0] pixels_per_line_q;
  logic [vdft_pkg::CNT_W-1:0] lines_per_picture_q;
  logic [vdft_pkg::CNT_W-1:0] pixel_q;
  logic [vdft_pkg::CNT_W-1:0] pixel_d;
  logic [vdft_pkg::CNT_W-1:0] line_q;
  logic [vdft_pkg::CNT_W-1:0] line_d;
  vdft_pkg::vdft_state_e state_q;
  vdft_pkg::vdft_state_e state_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  vdft_pkg::vdft_timing_s timing_q;
  vdft_pkg::vdft_timing_s timing_d;
  vdft_pkg::vdft_format_s format_sel_q;

  // ****************************************
  // Bus decode
  // ****************************************
  wire hit_ctl = addr_hit(bus_req.addr, vdft_pkg::OFS_DISPLAY_CONTROL);
  wire hit_size = addr_hit(bus_req.addr, vdft_pkg::OFS_DISPLAY_FRAME_SIZE);
  wire hit_stat = addr_hit(bus_req.addr, vdft_pkg::OFS_DISPLAY_STATUS);
  wire wr_ctl = bus_req.wr && hit_ctl;
  wire wr_size = bus_req.wr && hit_size;
  wire [31:0] wd = bus_req.wdata;
  // Channel reset is a self-clearing command, never stored
  wire chan_reset = wr_ctl && wd[vdft_pkg::CTL_CHAN_RST_BIT];

  // ****************************************
  // Write data fields
  // ****************************************
  // Reserved bits never reach a register
  wire [vdft_pkg::FMT_W-1:0] wd_format = wd[vdft_pkg::CTL_FMT_LSB +: vdft_pkg::FMT_W];
  wire wd_first = wd[vdft_pkg::CTL_FIRST_BIT];
  wire wd_second = wd[vdft_pkg::CTL_SECOND_BIT];
  wire wd_whole = wd[vdft_pkg::CTL_WHOLE_BIT];
  wire wd_repeat = wd[vdft_pkg::CTL_REPEAT_BIT];
  // Channel reset wins over an enable set in the same write
  wire wd_enable = wd[vdft_pkg::CTL_ENABLE_BIT] && !chan_reset;
  wire wd_blank_dis = wd[vdft_pkg::CTL_BLANK_DIS_BIT];
  wire [vdft_pkg::CNT_W-1:0] wd_width = wd[vdft_pkg::SIZE_WIDTH_LSB +: vdft_pkg::CNT_W];
  wire [vdft_pkg::CNT_W-1:0] wd_height = wd[vdft_pkg::SIZE_HEIGHT_LSB +: vdft_pkg::CNT_W];

  // ****************************************
  // Read words
  // ****************************************
  // Reserved bits are left at zero by construction
  wire [31:0] ctl_word = vdft_pkg::WORD_ZERO
    | (32'(format_q) << vdft_pkg::CTL_FMT_LSB)
    | (32'(show_first_field_q) << vdft_pkg::CTL_FIRST_BIT)
    | (32'(show_second_field_q) << vdft_pkg::CTL_SECOND_BIT)
    | (32'(show_whole_picture_q) << vdft_pkg::CTL_WHOLE_BIT)
    | (32'(repeat_display_enable_q) << vdft_pkg::CTL_REPEAT_BIT)
    | (32'(display_enable_bit_q) << vdft_pkg::CTL_ENABLE_BIT)
    | (32'(blanking_disable_bit_q) << vdft_pkg::CTL_BLANK_DIS_BIT);

  wire [31:0] size_word = vdft_pkg::WORD_ZERO
    | (32'(pixels_per_line_q) << vdft_pkg::SIZE_WIDTH_LSB)
    | (32'(lines_per_picture_q) << vdft_pkg::SIZE_HEIGHT_LSB);

  wire [31:0] stat_word = vdft_pkg::WORD_ZERO
    | (32'(pixel_q) << vdft_pkg::STAT_PIXEL_LSB)
    | (32'(line_q) << vdft_pkg::STAT_LINE_LSB)
    | (32'(timing_d.second_field) << vdft_pkg::STAT_FIELD_BIT)
    | (32'(timing_d.field_shown) << vdft_pkg::STAT_SHOWN_BIT)
    | (32'(state_q == vdft_pkg::ST_RUN) << vdft_pkg::STAT_BUSY_BIT);

  always_comb begin
    rdata_d = vdft_pkg::WORD_ZERO;
    if (bus_req.rd) begin
      if (hit_ctl) begin
        rdata_d = ctl_word;
      end else if (hit_size) begin
        rdata_d = size_word;
      end else if (hit_stat) begin
        rdata_d = stat_word;
      end
    end
  end

  // ****************************************
  // Counter wrap points
  // ****************************************
  // Width of zero wraps every pixel rather than running through 4096
  wire [vdft_pkg::CNT_W-1:0] pixel_last = (pixels_per_line_q == '0) ? '0 :
    pixels_per_line_q - vdft_pkg::CNT_ONE;
  wire pixel_wrap = pixel_q >= pixel_last;
  // Height below one behaves as a one-line picture
  wire line_wrap = line_q >= lines_per_picture_q;
  wire frame_wrap = pixel_wrap && line_wrap;

  // ****************************************
  // Field selection
  // ****************************************
  // Field two starts past the midpoint; an odd line goes to field one
  wire [vdft_pkg::CNT_W-1:0] half_lines =
    (lines_per_picture_q >> 1) + {{(vdft_pkg::CNT_W-1){1'b0}}, lines_per_picture_q[0]};
  wire in_second = line_q > half_lines;
  wire pick_second = show_second_field_q && in_second;
  wire pick_first = show_first_field_q && !in_second;
  wire field_selected = show_whole_picture_q || pick_second || pick_first;

  // ****************************************
  // Sequencer
  // ****************************************
  // RUN walks one picture unless repeat is set; DONE holds until the enable is dropped,
  // so a one-shot picture is not restarted by a stale enable.
  always_comb begin
    state_d = state_q;
    case (state_q)
      vdft_pkg::ST_IDLE: begin
        if (display_enable_bit_q) begin
          state_d = vdft_pkg::ST_RUN;
        end
      end
      vdft_pkg::ST_RUN: begin
        if (!display_enable_bit_q) begin
          state_d = vdft_pkg::ST_IDLE;
        end else if (frame_wrap && !repeat_display_enable_q) begin
          state_d = vdft_pkg::ST_DONE;
        end
      end
      vdft_pkg::ST_DONE: begin
        if (!display_enable_bit_q) begin
          state_d = vdft_pkg::ST_IDLE;
        end
      end
      default: state_d = vdft_pkg::ST_IDLE;
    endcase
    if (chan_reset) begin
      state_d = vdft_pkg::ST_IDLE;
    end
  end

  wire running = state_q == vdft_pkg::ST_RUN;

  // ****************************************
  // Position counters
  // ****************************************
  always_comb begin
    pixel_d = pixel_q;
    line_d = line_q;
    if (chan_reset || !running) begin
      pixel_d = vdft_pkg::PIXEL_START;
      line_d = vdft_pkg::LINE_START;
    end else if (pixel_wrap) begin
      pixel_d = vdft_pkg::PIXEL_START;
      line_d = line_wrap ? vdft_pkg::LINE_START : line_q + vdft_pkg::CNT_ONE;
    end else begin
      pixel_d = pixel_q + vdft_pkg::CNT_ONE;
    end
  end

  // ****************************************
  // Timing outputs
  // ****************************************
  always_comb begin
    timing_d = '0;
    timing_d.pixel_position_counter = pixel_q;
    timing_d.line_position_counter = line_q;
    timing_d.second_field = in_second;
    timing_d.field_shown = running && field_selected;
    timing_d.frame_end = running && frame_wrap;
    timing_d.running = running;
  end

  // ****************************************
  // Control register
  // ****************************************
  // Writes are taken as they come; holding the enable low while
  // changing the other fields is left to software.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      format_q <= vdft_pkg::FORMAT_8BIT_ITU;
    end else if (clk_en && wr_ctl) begin
      format_q <= wd_format;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      show_first_field_q <= 1'b0;
      show_second_field_q <= 1'b0;
      show_whole_picture_q <= 1'b0;
    end else if (clk_en && wr_ctl) begin
      show_first_field_q <= wd_first;
      show_second_field_q <= wd_second;
      show_whole_picture_q <= wd_whole;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      repeat_display_enable_q <= 1'b0;
      display_enable_bit_q <= 1'b0;
    end else if (clk_en && wr_ctl) begin
      repeat_display_enable_q <= wd_repeat;
      display_enable_bit_q <= wd_enable;
    end
  end

  // Blanking disable may legally change while the display runs
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      blanking_disable_bit_q <= 1'b0;
    end else if (clk_en && wr_ctl) begin
      blanking_disable_bit_q <= wd_blank_dis;
    end
  end

  // ****************************************
  // Frame size register
  // ****************************************
  // Reserved size bits are simply not stored, so they read zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pixels_per_line_q <= '0;
      lines_per_picture_q <= '0;
    end else if (clk_en && wr_size) begin
      pixels_per_line_q <= wd_width;
      lines_per_picture_q <= wd_height;
    end
  end

  // ****************************************
  // Sequencer and counter state
  // ****************************************
  // State and counters share clk_en so they can never drift apart
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_q <= vdft_pkg::ST_IDLE;
      pixel_q <= vdft_pkg::PIXEL_START;
      line_q <= vdft_pkg::LINE_START;
    end else if (clk_en) begin
      state_q <= state_d;
      pixel_q <= pixel_d;
      line_q <= line_d;
    end
  end

  // ****************************************
  // Output and read-data flops
  // ****************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdata_q <= vdft_pkg::WORD_ZERO;
    end else if (clk_en) begin
      rdata_q <= rdata_d;
    end
  end

  // One stage toward the encoder; positions lag the counters a cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      timing_q <= '0;
    end else if (clk_en) begin
      timing_q <= timing_d;
    end
  end

  // Registered so the encoder sees clean levels: one-hot, or all zero for codes 1, 3, 5 and 7
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      format_sel_q <= '0;
    end else if (clk_en) begin
      format_sel_q <= decode_format(format_q);
    end
  end

  assign bus_rdata = rdata_q;
  assign timing = timing_q;
  assign format_sel = format_sel_q;
  assign blanking_disable = blanking_disable_bit_q;

endmodule // vdft_frame_timing

`default_nettype wire

// ==== verilog/vdft_pkg.sv ====
// Package for the display frame timing block: register map, field layout,
// reset values, state and format encodings, bus and timing carriers.
// Assumes a single 50 MHz clock; all users refer to items as vdft_pkg::name.
`default_nettype none

package vdft_pkg;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_DISPLAY_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_DISPLAY_FRAME_SIZE = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_DISPLAY_STATUS = 8'h08;

  // ****************************************
  // Field layout
  // ****************************************
  localparam int CNT_W = 12;
  localparam int FMT_W = 3;
  localparam int CTL_FMT_LSB = 0;
  localparam int CTL_RSVD_BIT = 3;
  localparam int CTL_FIRST_BIT = 4;
  localparam int CTL_SECOND_BIT = 5;
  localparam int CTL_WHOLE_BIT = 6;
  localparam int CTL_REPEAT_BIT = 7;
  localparam int CTL_ENABLE_BIT = 15;
  localparam int CTL_BLANK_DIS_BIT = 30;
  localparam int CTL_CHAN_RST_BIT = 31;
  localparam int SIZE_WIDTH_LSB = 0;
  localparam int SIZE_HEIGHT_LSB = 16;
  localparam int STAT_PIXEL_LSB = 0;
  localparam int STAT_LINE_LSB = 16;
  localparam int STAT_FIELD_BIT = 29;
  localparam int STAT_SHOWN_BIT = 30;
  localparam int STAT_BUSY_BIT = 31;

  // ****************************************
  // Reset and start values
  // ****************************************
  localparam logic [CNT_W-1:0] PIXEL_START = 12'h000;
  localparam logic [CNT_W-1:0] LINE_START = 12'h001;
  localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // ****************************************
  // Encodings
  // ****************************************
  typedef enum logic [FMT_W-1:0] {
    FORMAT_8BIT_ITU = 3'h0,
    FORMAT_8BIT_UNFORMATTED = 3'h2,
    FORMAT_LUMA_CHROMA = 3'h4,
    FORMAT_16BIT_UNFORMATTED = 3'h6
  } vdft_format_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_DONE = 2'b10
  } vdft_state_e;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } vdft_bus_req_s;

  typedef struct packed {
    logic fmt_8bit_itu;
    logic fmt_8bit_unformatted;
    logic fmt_luma_chroma;
    logic fmt_16bit_unformatted;
  } vdft_format_s;

  typedef struct packed {
    logic [CNT_W-1:0] pixel_position_counter;
    logic [CNT_W-1:0] line_position_counter;
    logic second_field;
    logic field_shown;
    logic frame_end;
    logic running;
  } vdft_timing_s;

endpackage

`default_nettype wire

// ==== test/vdft_sink.sv ====
// Encoder-side model: counts finished frames and shown pixel cycles.
// Assumes it watches the timing outputs directly, with clk_en held high.
`timescale 1ns/100ps
`default_nettype none
module vdft_sink (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Timing from the block
  input wire vdft_pkg::vdft_timing_s timing,
  // Counts for the bench
  output logic [15:0] frames_q,
  output logic [15:0] shown_q
);
  // Counters only: a real encoder just consumes whatever the block shows
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      frames_q <= 16'h0000;
      shown_q <= 16'h0000;
    end else begin
      frames_q <= frames_q + 16'(timing.frame_end);
      shown_q <= shown_q + 16'(timing.field_shown);
    end
  end
endmodule // vdft_sink
`default_nettype wire

// ==== test/vdft_chk.sv ====
// Port checker for the frame timing block, bound to every instance.
// Assumes clk_en high and control fields changed only while idle.
`timescale 1ns/100ps
`default_nettype none
module vdft_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  // Register port
  input wire vdft_pkg::vdft_bus_req_s bus_req,
  input wire logic [31:0] bus_rdata,
  // Encoder side
  input wire vdft_pkg::vdft_timing_s timing,
  input wire vdft_pkg::vdft_format_s format_sel,
  input wire logic blanking_disable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ****************************************
  // Shadow of the writable fields
  // ****************************************
  logic [31:0] ctl_q;
  logic [31:0] size_q;
  wire logic wr_ctl = clk_en && bus_req.wr && bus_req.addr == vdft_pkg::OFS_DISPLAY_CONTROL;
  wire logic wr_size = clk_en && bus_req.wr && bus_req.addr == vdft_pkg::OFS_DISPLAY_FRAME_SIZE;
  wire logic rd_ctl = clk_en && bus_req.rd && bus_req.addr == vdft_pkg::OFS_DISPLAY_CONTROL;
  wire logic rd_size = clk_en && bus_req.rd && bus_req.addr == vdft_pkg::OFS_DISPLAY_FRAME_SIZE;
  wire logic run = timing.running;
  wire logic [11:0] pix = timing.pixel_position_counter;
  wire logic [11:0] lin = timing.line_position_counter;
  wire logic [11:0] wid = size_q[11:0];
  wire logic [11:0] hgt = size_q[27:16];
  wire logic [2:0] fc = ctl_q[2:0];
  wire logic [3:0] fmt_exp = {fc == 3'h0, fc == 3'h2, fc == 3'h4, fc == 3'h6};
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctl_q <= 32'h0000_0000;
      size_q <= 32'h0000_0000;
    end else begin
      if (wr_ctl) begin
        ctl_q <= bus_req.wdata;
      end
      if (wr_size) begin
        size_q <= bus_req.wdata & 32'h0FFF_0FFF;
      end
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  a_pixel_step: assert property ((run && $past(run) && pix != 12'h000) |-> pix == $past(pix) + 12'h001)
    else $error("pixel counter skipped");
  a_pixel_range: assert property ((run && wid != 12'h000) |-> pix < wid)
    else $error("pixel counter beyond width");
  a_line_range: assert property (run |-> lin != 12'h000 && (lin <= hgt || lin == 12'h001))
    else $error("line counter out of range");
  a_line_step: assert property ((run && $past(run) && lin != $past(lin)) |-> pix == 12'h000)
    else $error("line moved without pixel wrap");
  a_frame_end: assert property (timing.frame_end |-> run && pix == wid - 12'h001 && lin == hgt)
    else $error("frame end at wrong place");
  a_size_read: assert property ($past(rd_size) |-> bus_rdata == $past(size_q))
    else $error("frame size readback wrong");
  a_ctl_rsvd: assert property ($past(rd_ctl) |-> !bus_rdata[3])
    else $error("control bit three not zero");
  a_format_map: assert property (wr_ctl |-> ##[1:2] format_sel == fmt_exp)
    else $error("format select wrong");
  // Shown flag was formed from the control bits one cycle back
  a_field_sel: assert property (run |-> timing.field_shown == ($past(ctl_q[6])
    || ($past(ctl_q[4]) && !timing.second_field) || ($past(ctl_q[5]) && timing.second_field)))
    else $error("field shown wrong");
  a_repeat_run: assert property ((timing.frame_end && ctl_q[7]) |=> run [*3])
    else $error("repeat display stopped");
  a_single_stop: assert property ((timing.frame_end && !ctl_q[7]) |-> ##[1:2] !run)
    else $error("single frame kept running");
endmodule // vdft_chk
bind vdft_frame_timing vdft_chk u_chk (.sys_clk, .rst, .clk_en, .bus_req, .bus_rdata, .timing, .format_sel,
  .blanking_disable);
`default_nettype wire

// ==== test/tb_video_display_frame_timing.sv ====
// Bench for the frame timing block: registers, formats, fields, repeat, reset.
// Assumes one 50 MHz clock and clk_en held high throughout.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %s exp %h seen %h", n, e, g); end end
module tb_video_display_frame_timing;
  localparam logic [7:0] CTL = vdft_pkg::OFS_DISPLAY_CONTROL;
  localparam logic [7:0] SIZE = vdft_pkg::OFS_DISPLAY_FRAME_SIZE;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  vdft_pkg::vdft_bus_req_s bus_req = '0;
  logic [31:0] bus_rdata;
  vdft_pkg::vdft_timing_s timing;
  vdft_pkg::vdft_format_s format_sel;
  logic blanking_disable;
  logic [15:0] frames_q;
  logic [15:0] shown_q;
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  vdft_frame_timing dut (.sys_clk, .rst, .clk_en, .bus_req, .bus_rdata, .timing, .format_sel, .blanking_disable);
  vdft_sink u_sink (.sys_clk, .rst, .timing, .frames_q, .shown_q);
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  // Runaway guard, far above the few hundred cycles needed
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      results();
    end
  end
  // ****************************************
  // Bus and helper tasks
  // ****************************************
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask
  task rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    bus_req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    #1;
    `CHK(n, e, bus_rdata)
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_regs;
    rchk("size reset", SIZE, 32'h0000_0000);
    wr(SIZE, 32'hFFFF_FFFF);
    rchk("size mask", SIZE, 32'h0FFF_0FFF);
    wr(SIZE, 32'h020D_035A);
    rchk("size 525x858", SIZE, 32'h020D_035A);
    wr(SIZE, 32'h0271_0360);
    rchk("size 625x864", SIZE, 32'h0271_0360);
    wr(CTL, 32'h4000_00FF);
    rchk("ctl bit3", CTL, 32'h4000_00F7);
    `CHK("blanking", 1'b1, blanking_disable)
    rchk("unmapped", 8'h0C, 32'h0000_0000);
  endtask
  task t_formats;
    for (int i = 0; i < 4; i++) begin
      wr(CTL, 32'(2 * i));
      tick(2);
      `CHK("format", 4'h8 >> i, format_sel)
    end
  endtask
  task t_fields;
    logic [31:0] bits [4];
    logic [15:0] exp [4];
    logic [15:0] f0;
    logic [15:0] s0;
    bits = '{32'h0000_0040, 32'h0000_0010, 32'h0000_0020, 32'h0000_0000};
    // Height 4 splits at line 2, so each field holds 2 lines of 3 pixels
    exp = '{16'h000C, 16'h0006, 16'h0006, 16'h0000};
    for (int i = 0; i < 4; i++) begin
      wr(CTL, 32'h0000_0000);
      wr(SIZE, 32'h0004_0003);
      f0 = frames_q;
      s0 = shown_q;
      wr(CTL, bits[i] | 32'h0000_8000);
      tick(40);
      `CHK("shown", exp[i], shown_q - s0)
      `CHK("one frame", 16'h0001, frames_q - f0)
      `CHK("stopped", 1'b0, timing.running)
    end
  endtask
  task t_repeat;
    logic [7:0] n;
    n = 8'h00;
    wr(CTL, 32'h0000_0000);
    wr(SIZE, 32'h0002_0003);
    wr(CTL, 32'h0000_80C0);
    for (int k = 0; k < 50 && timing.frame_end !== 1'b1; k++) begin
      tick(1);
    end
    // Frame of 6 pixel clocks, so 18 clocks hold 3 more ends
    repeat (18) begin
      tick(1);
      n = n + 8'(timing.frame_end);
    end
    `CHK("repeat frames", 8'h03, n)
    // Keep the reset clear of the last frame end's three run cycles
    tick(2);
    wr(CTL, 32'h8000_0000);
    tick(3);
    `CHK("channel reset", 1'b0, timing.running)
  endtask
  task results;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_formats();
    t_fields();
    t_repeat();
    results();
  end
endmodule // tb_video_display_frame_timing
`default_nettype wire
